//--- src/teh_handshake.sv
// ============================================================
// Purpose: trigger input, end-of-measurement and decision
//          outputs of the external control connector
// Assumes: measurement core answers meas_go with meas_done
// Notes:   result readback never stalls and is never stalled
`timescale 1ns/1ps

module teh_handshake #(
    parameter int CYC_PER_MS = teh_pkg::CYC_PER_MS
) (
    input  wire logic                     mclk,
    input  wire logic                     nrst,
    input  wire logic                     measure_start_in_n,
    input  wire teh_pkg::teh_cfg_t        cfg,
    input  wire logic                     init_done,
    input  wire logic                     meas_done,
    input  wire teh_pkg::teh_result_t     meas_result,
    input  wire logic                     rd_req,
    output logic                          rd_ack,
    output teh_pkg::teh_result_t          rd_data,
    output logic                          meas_go,
    output logic                          measure_done_out_n,
    output logic [teh_pkg::DEC_W-1:0]     decision_out_n
);
    import teh_pkg::*;

    typedef enum logic [2:0] {
        ST_INIT,
        ST_IDLE,
        ST_MEAS,
        ST_HOLD,
        ST_PULSE
    } teh_state_t;

    localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(CYC_PER_MS - 1);

    teh_state_t          state_r,  state_nxt;
    logic                eom_n_r,  eom_n_nxt;
    logic [DEC_W-1:0]    dec_n_r,  dec_n_nxt;
    logic                go_r,     go_nxt;
    logic [CYC_W-1:0]    cyc_r,    cyc_nxt;
    logic [PW_W-1:0]     ms_r,     ms_nxt;
    teh_result_t         res_r,    res_nxt;
    logic                measure_start_in_start;
    logic                can_start;

    // ============================================================
    // trigger front end
    teh_measure_start_in_edge u_measure_start_in (
        .mclk      (mclk),
        .nrst      (nrst),
        .pin_n     (measure_start_in_n),
        .measure_start_in_edge (cfg.measure_start_in_edge),
        .start     (measure_start_in_start)
    );

    // a trigger is only taken once running and not mid-measurement
    assign can_start = (state_r == ST_IDLE) || (state_r == ST_HOLD) ||
                       (state_r == ST_PULSE);

    // ============================================================
    // handshake state machine
    always_comb begin
        state_nxt = state_r;
        eom_n_nxt = eom_n_r;
        dec_n_nxt = dec_n_r;
        go_nxt    = 1'b0;
        cyc_nxt   = cyc_r;
        ms_nxt    = ms_r;
        case (state_r)
            ST_INIT: begin
                eom_n_nxt = PIN_ON;
                dec_n_nxt = {DEC_W{PIN_ON}};
                if (init_done) begin
                    state_nxt = ST_IDLE;
                    eom_n_nxt = PIN_OFF;
                    dec_n_nxt = {DEC_W{PIN_OFF}};
                end
            end
            ST_MEAS: begin
                if (meas_done) begin
                    dec_n_nxt = ~meas_result.pass;
                    eom_n_nxt = PIN_ON;
                    cyc_nxt   = '0;
                    ms_nxt    = PW_W'(1);
                    state_nxt = cfg.pulse_mode ? ST_PULSE : ST_HOLD;
                end
            end
            ST_PULSE: begin
                if (cyc_r == CYC_LAST) begin
                    cyc_nxt = '0;
                    if (ms_r >= cfg.pulse_ms) begin
                        eom_n_nxt = PIN_OFF;
                        state_nxt = ST_IDLE;
                    end else begin
                        ms_nxt = ms_r + PW_W'(1);
                    end
                end else begin
                    cyc_nxt = cyc_r + CYC_W'(1);
                end
            end
            default: begin
            end
        endcase
        // a new trigger overrides hold, pulse and idle
        if (can_start && measure_start_in_start) begin
            state_nxt = ST_MEAS;
            go_nxt    = 1'b1;
            eom_n_nxt = PIN_OFF;
            dec_n_nxt = {DEC_W{PIN_OFF}};
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_INIT;
            eom_n_r <= PIN_ON;
            dec_n_r <= {DEC_W{PIN_ON}};
            go_r    <= 1'b0;
            cyc_r   <= '0;
            ms_r    <= '0;
        end else begin
            state_r <= state_nxt;
            eom_n_r <= eom_n_nxt;
            dec_n_r <= dec_n_nxt;
            go_r    <= go_nxt;
            cyc_r   <= cyc_nxt;
            ms_r    <= ms_nxt;
        end
    end

    // ============================================================
    // result holding register for the communications side
    always_comb begin
        res_nxt = res_r;
        if (state_r == ST_MEAS && meas_done) begin
            res_nxt = meas_result;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            res_r <= '0;
        end else begin
            res_r <= res_nxt;
        end
    end

    assign rd_ack             = rd_req;
    assign rd_data            = res_r;
    assign meas_go            = go_r;
    assign measure_done_out_n = eom_n_r;
    assign decision_out_n     = dec_n_r;

    // ============================================================
    // checks
    int unsigned pulse_len_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pulse_len_r <= 0;
        end else begin
            pulse_len_r <= (state_r == ST_PULSE) ? pulse_len_r + 1 : 0;
        end
    end

    AST_HOLD_KEEPS: assert property (
        @(posedge mclk) disable iff (!nrst)
        (state_r == ST_HOLD && !measure_start_in_start) |=>
            (measure_done_out_n == PIN_ON) && (state_r == ST_HOLD))
        else $error("done output dropped in hold without trigger");

    AST_PULSE_WIDTH: assert property (
        @(posedge mclk) disable iff (!nrst)
        ($past(state_r) == ST_PULSE && state_r == ST_IDLE) |->
            (pulse_len_r == ((cfg.pulse_ms == '0) ? 1 :
                             int'(cfg.pulse_ms)) * CYC_PER_MS) &&
            (measure_done_out_n == PIN_OFF))
        else $error("done pulse width wrong");

    AST_EDGE_GO: assert property (
        @(posedge mclk) disable iff (!nrst)
        (can_start && measure_start_in_start) |=> meas_go ##1 !meas_go)
        else $error("trigger edge did not start one measurement");

    AST_DEC_OFF: assert property (
        @(posedge mclk) disable iff (!nrst)
        (state_r == ST_MEAS) |-> (decision_out_n == {DEC_W{PIN_OFF}}))
        else $error("decision output active during measurement");

    AST_DEC_SET: assert property (
        @(posedge mclk) disable iff (!nrst)
        (state_r == ST_MEAS && meas_done && !measure_start_in_start) |=>
            (decision_out_n == ~$past(meas_result.pass)))
        else $error("decision not taken at end of measurement");

    AST_READ_FREE: assert property (
        @(posedge mclk) disable iff (!nrst)
        rd_req |-> rd_ack && (rd_data == res_r))
        else $error("readback was stalled");

    AST_READ_LATEST: assert property (
        @(posedge mclk) disable iff (!nrst)
        (state_r == ST_MEAS && meas_done) |=>
            (rd_data == $past(meas_result)))
        else $error("readback does not show the latest result");

    AST_NEW_MEASURE_START_IN_OFF: assert property (
        @(posedge mclk) disable iff (!nrst)
        ((state_r == ST_HOLD || state_r == ST_PULSE) && measure_start_in_start) |=>
            (measure_done_out_n == PIN_OFF) && (state_r == ST_MEAS))
        else $error("done output not released by new trigger");

    AST_POWER_ON: assert property (
        @(posedge mclk) disable iff (!nrst)
        (state_r == ST_INIT && init_done) |->
            (measure_done_out_n == PIN_ON) ##1
            (measure_done_out_n == PIN_OFF &&
             decision_out_n == {DEC_W{PIN_OFF}}))
        else $error("outputs wrong around start of operation");

endmodule : teh_handshake

//--- src/teh_measure_start_in_edge.sv
// ============================================================
// Purpose: synchronise the trigger pin and pick out one edge
// Assumes: pin may change at any time relative to mclk
// Notes:   one start pulse per qualifying edge
`timescale 1ns/1ps
module teh_measure_start_in_edge (
    input  wire logic          mclk,
    input  wire logic          nrst,
    input  wire logic          pin_n,
    input  wire teh_pkg::teh_edge_t measure_start_in_edge,
    output logic               start
);
    import teh_pkg::*;

    logic [2:0] sh_r;
    logic [2:0] sh_nxt;

    // ============================================================
    // synchroniser plus history stage; sh_r[0] feeds only sh_r[1]
    always_comb begin
        sh_nxt = {sh_r[1:0], pin_n};
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sh_r <= {3{PIN_OFF}};
        end else begin
            sh_r <= sh_nxt;
        end
    end

    // edge detect on synchronised samples only
    assign start = (measure_start_in_edge == TEH_EDGE_RISE) ?
                   (sh_r[1] & ~sh_r[2]) :
                   (~sh_r[1] & sh_r[2]);

    AST_ONE_START: assert property (
        @(posedge mclk) disable iff (!nrst)
        start |=> !start)
        else $error("start pulse lasted more than one cycle");

endmodule : teh_measure_start_in_edge

//--- src/teh_pkg.sv
// ============================================================
// Purpose: shared constants and types for the trigger/end-of-
//          measurement handshake block
// Assumes: 100 MHz mclk, active-low external pins
// Notes:   timing counts are derived from times in their own unit
package teh_pkg;

    // ============================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1000000;
    localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;

    // ============================================================
    // widths and reset values
    localparam int  DEC_W        = 3;     // comparator decision outputs
    localparam int  VAL_W        = 32;    // measured value word
    localparam int  PW_W         = 7;     // pulse width in ms, 1..127, 0 acts as 1
    localparam int  CYC_W        = 24;
    localparam logic PIN_OFF     = 1'b1;  // active-low pin deasserted
    localparam logic PIN_ON      = 1'b0;  // active-low pin asserted

    // ============================================================
    // types
    typedef enum logic {
        TEH_EDGE_FALL,
        TEH_EDGE_RISE
    } teh_edge_t;

    typedef struct packed {
        teh_edge_t         measure_start_in_edge;   // which trigger edge starts
        logic              pulse_mode;  // 1: pulse, 0: hold
        logic [PW_W-1:0]   pulse_ms;    // pulse width in ms
    } teh_cfg_t;

    typedef struct packed {
        logic [DEC_W-1:0]  pass;        // per-comparator decision
        logic [VAL_W-1:0]  value;       // measured value
    } teh_result_t;

endpackage : teh_pkg

//--- verif/teh_handshake_bench.sv
// ============================================================
// Purpose: self-checking bench for the trigger handshake block
// Assumes: short ms count, bench plays the measurement core
// Notes:   all inputs change at the falling edge of mclk
`timescale 1ns/1ps
module teh_handshake_bench;
    import teh_pkg::*;
    localparam int CYC = 4;
    logic        mclk        = 1'b0;
    logic        nrst        = 1'b0;
    logic        press       = 1'b0;
    logic        init_done   = 1'b0;
    logic        meas_done   = 1'b0;
    logic        rd_req      = 1'b0;
    teh_cfg_t    cfg         = '{TEH_EDGE_FALL, 1'b0, 7'h01};
    teh_result_t meas_result = '0;
    teh_result_t rd_data;
    logic        rd_ack, meas_go, eom_n, pin_n;
    logic [DEC_W-1:0] dec_n;
    int          errors = 0, compares = 0, go_cnt = 0, n;

    // ============================================================
    // clock and start pulse counter
    always #5 mclk = ~mclk;
    always @(posedge mclk) if (meas_go === 1'b1) go_cnt <= go_cnt + 1;

    teh_plc_model teh_plc_model_i (.press(press),
        .measure_start_in_n(pin_n));
    teh_handshake #(.CYC_PER_MS(CYC)) teh_handshake_i (.mclk(mclk),
        .nrst(nrst), .measure_start_in_n(pin_n), .cfg(cfg),
        .init_done(init_done), .meas_done(meas_done),
        .meas_result(meas_result), .rd_req(rd_req), .rd_ack(rd_ack),
        .rd_data(rd_data), .meas_go(meas_go),
        .measure_done_out_n(eom_n), .decision_out_n(dec_n));

    // ============================================================
    // shared tasks
    task automatic check(input string name, input logic [34:0] seen,
                         input logic [34:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask : cyc

    // move the pin, then count the starts that follow
    task automatic pin(input logic p, input int exp_go);
        int g;
        g = go_cnt;
        press = p;
        cyc(10);
        check("start count", 35'(go_cnt - g), 35'(exp_go));
    endtask : pin

    // end a measurement with the given decisions
    task automatic done(input logic [DEC_W-1:0] p, input logic [31:0] v);
        logic [DEC_W-1:0] exp_dec;
        exp_dec = ~p;
        meas_result = {p, v};
        meas_done = 1'b1;
        cyc(1);
        meas_done = 1'b0;
        check("eom at end", 35'(eom_n), 35'(PIN_ON));
        check("decisions", 35'(dec_n), 35'(exp_dec));
        rd_req = 1'b1;
        #1 check("readback", 35'(rd_data), 35'({p, v}));
        check("read ack", 35'(rd_ack), 35'h1);
        cyc(1);
        rd_req = 1'b0;
    endtask : done

    task automatic close_out;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // ============================================================
    // scenarios: power-on, hold, pulse, rising edge
    task automatic t_init;
        repeat (2) @(posedge mclk);
        @(negedge mclk) nrst = 1'b1;
        check("init eom", 35'(eom_n), 35'(PIN_ON));
        check("init dec", 35'(dec_n), 35'h0);
        pin(1'b1, 0);
        pin(1'b0, 0);
        init_done = 1'b1;
        cyc(2);
        check("run eom", 35'(eom_n), 35'(PIN_OFF));
        check("run dec", 35'(dec_n), 35'h7);
    endtask : t_init

    task automatic t_hold;
        pin(1'b1, 1);
        check("eom off", 35'(eom_n), 35'(PIN_OFF));
        check("dec off", 35'(dec_n), 35'h7);
        pin(1'b0, 0);
        rd_req = 1'b1;
        #1 check("read busy", 35'(rd_ack), 35'h1);
        check("read old", 35'(rd_data), 35'h0);
        cyc(1);
        rd_req = 1'b0;
        done(3'h5, 32'hA5C3_0F12);
        cyc(30);
        check("eom held", 35'(eom_n), 35'(PIN_ON));
        pin(1'b1, 1);
        check("eom cleared", 35'(eom_n), 35'(PIN_OFF));
        check("dec cleared", 35'(dec_n), 35'h7);
        done(3'h3, 32'h0000_1234);
        pin(1'b0, 0);
    endtask : t_hold

    task automatic t_pulse;
        cfg = '{TEH_EDGE_FALL, 1'b1, 7'h02};
        pin(1'b1, 1);
        done(3'h6, 32'h7E00_0001);
        n = 1;
        while (eom_n === PIN_ON && n < 100) begin
            n++;
            cyc(1);
        end
        check("pulse length", 35'(n), 35'(2 * CYC));
        cyc(5);
        check("eom after pulse", 35'(eom_n), 35'(PIN_OFF));
        // a new trigger in mid-pulse cuts the pulse short
        pin(1'b0, 0);
        cfg.pulse_ms = 7'h10;
        pin(1'b1, 1);
        done(3'h2, 32'h0BAD_F00D);
        pin(1'b0, 0);
        check("eom in pulse", 35'(eom_n), 35'(PIN_ON));
        pin(1'b1, 1);
        check("eom cut", 35'(eom_n), 35'(PIN_OFF));
        done(3'h4, 32'h0000_0042);
        cyc(70);
        check("eom after long pulse", 35'(eom_n), 35'(PIN_OFF));
    endtask : t_pulse

    task automatic t_rise;
        cfg = '{TEH_EDGE_RISE, 1'b0, 7'h01};
        pin(1'b0, 1);
        done(3'h1, 32'hFFFF_FFFF);
        pin(1'b1, 0);
        check("eom hold", 35'(eom_n), 35'(PIN_ON));
    endtask : t_rise

    // ============================================================
    // main sequence and watchdog
    initial begin
        t_init();
        t_hold();
        t_pulse();
        t_rise();
        close_out();
    end

    initial begin
        #(5000 * 10);
        errors++;
        close_out();
    end
endmodule : teh_handshake_bench

//--- verif/teh_plc_model.sv
// ============================================================
// Purpose: external controller model driving the trigger pin
// Assumes: bench sets press at the falling edge of mclk
// Notes:   pin idles released, pulled to common while pressed
`timescale 1ns/1ps
module teh_plc_model (
    input  wire logic press,
    output logic      measure_start_in_n
);
    import teh_pkg::*;

    // ============================================================
    // pin driver: follows press at once, so the pin moves on the
    // same falling edge as press and never races a clocked copy
    assign measure_start_in_n = press ? PIN_ON : PIN_OFF;
endmodule : teh_plc_model
